/* hdl/cyclic_timer_ctrl.v */
// cyclic timers and high-side shutdown control with serial register port
// assumes register strobes are one-cycle pulses synchronous to core_clk
// What this block does
// - second timer on-time decode, two stopped codes
// - on-time code 111 acts like 110
// - second timer period decode 10 ms to 2 s
// - first timer on-time decoded like second
// - first timer period decode 10 ms to 2 s
// - wake select: none, first, second, reserved
// - reserved bits read zero, ignore writes
// - timer starts once running on-time written
// - restart clearing a timed switch clears timer
// - other failures keep timer settings
// - wake and sense run together from timer
// - overvoltage recovery restores previous switch state
// - overtemperature shuts all or only affected
// - third switch overvoltage shutdown in normal mode unless disabled
// - first, second switch overvoltage shutdown in normal mode unless disabled
`include "cyclic_timer_defines.vh"
module cyclic_timer_ctrl (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // serial register port, already deserialised
    input  wire [6:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [15:0] reg_rdata,
    // switch configuration from the switch control register
    input  wire [11:0] switch_config,
    // device state and fault inputs
    input  wire        normal_mode,
    input  wire        restart_entry,
    input  wire        overvolt,
    input  wire [2:0]  overtemp,
    // switch and wake outputs
    output reg  [2:0]  switch_drive,
    output reg         cyclic_wake,
    output reg  [1:0]  timer_pulse
);
    reg  [15:0] timer_ctrl_reg;    // cyclic timer control
    reg  [15:0] shutdown_ctrl_reg; // switch shutdown control
    reg  [14:0] step_one_reg;      // cycles into the first timer's 100 us step
    reg  [14:0] step_two_reg;      // cycles into the second timer's 100 us step
    reg  [2:0]  on_one_seen_reg;   // first on-time code as of last cycle
    reg  [2:0]  on_two_seen_reg;   // second on-time code as of last cycle
    reg  [1:0]  tick_reg;          // one-cycle step ticks, one bit per timer
    wire [2:0]  on_one;            // first timer on-time field
    wire [2:0]  on_two;            // second timer on-time field
    wire [1:0]  step_hold;         // timer stopped or restarting this cycle
    reg  [2:0]  ov_off_reg;        // switches held off by overvoltage
    reg  [2:0]  ov_latched_reg;    // switches left off after overvoltage
    reg         ov_prev_reg;       // overvoltage seen last cycle
    reg  [2:0]  restart_clear;     // switches on a timer at restart
    wire [1:0]  pulse;             // raw timer outputs
    wire [1:0]  wake_sel;          // wake selector field
    wire [2:0]  ov_dis;            // overvoltage shutdown disables
    reg  [2:0]  want_on;           // configured switch state
    reg  [2:0]  ov_hit;            // switches shut by overvoltage now
    reg  [15:0] timer_next;        // timer control next value
    integer     i;                 // loop index, switch decode
    integer     j;                 // loop index, overvoltage recovery
    integer     k;                 // loop index, switch outputs

    assign wake_sel = timer_ctrl_reg[`WAKE_SEL_LSB +: 2];
    assign ov_dis   = shutdown_ctrl_reg[`OV_DIS_ONE_BIT +: 3];
    assign on_one   = timer_ctrl_reg[`T1_ON_LSB +: 3];
    assign on_two   = timer_ctrl_reg[`T2_ON_LSB +: 3];
    // same stop and restart test as inside each timer, so a step starts with its period
    assign step_hold[0] = (on_one == 3'h0) || (on_one[2:1] == 2'b11) || (on_one != on_one_seen_reg);
    assign step_hold[1] = (on_two == 3'h0) || (on_two[2:1] == 2'b11) || (on_two != on_two_seen_reg);

    ////////////////////////////////////////////////////////////
    // one 100 us prescaler per timer from the core clock standing in for the oscillator;
    // a shared free-running one would cut the first on-time of a fresh code short
    always @(posedge core_clk) begin
        if (rst) begin
            step_one_reg    <= `TICK_FIRST;
            step_two_reg    <= `TICK_FIRST;
            on_one_seen_reg <= 3'h0;
            on_two_seen_reg <= 3'h0;
            tick_reg        <= 2'h0;
        end else begin
            on_one_seen_reg <= on_one;
            on_two_seen_reg <= on_two;
            // first timer step
            if (step_hold[0]) begin
                step_one_reg <= `TICK_FIRST;
                tick_reg[0]  <= 1'b0;
            end else if (step_one_reg == `TICK_LAST) begin
                step_one_reg <= 15'h0000;
                tick_reg[0]  <= 1'b1;
            end else begin
                step_one_reg <= step_one_reg + 15'h0001;
                tick_reg[0]  <= 1'b0;
            end
            // second timer step
            if (step_hold[1]) begin
                step_two_reg <= `TICK_FIRST;
                tick_reg[1]  <= 1'b0;
            end else if (step_two_reg == `TICK_LAST) begin
                step_two_reg <= 15'h0000;
                tick_reg[1]  <= 1'b1;
            end else begin
                step_two_reg <= step_two_reg + 15'h0001;
                tick_reg[1]  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // two identical timers
    cyclic_timer_unit timer_one (
        .core_clk    (core_clk),
        .rst         (rst),
        .tick        (tick_reg[0]),
        .period_code (timer_ctrl_reg[`T1_PER_LSB +: 3]),
        .on_code     (timer_ctrl_reg[`T1_ON_LSB +: 3]),
        .pulse_reg   (pulse[0])
    );
    cyclic_timer_unit timer_two (
        .core_clk    (core_clk),
        .rst         (rst),
        .tick        (tick_reg[1]),
        .period_code (timer_ctrl_reg[`T2_PER_LSB +: 3]),
        .on_code     (timer_ctrl_reg[`T2_ON_LSB +: 3]),
        .pulse_reg   (pulse[1])
    );

    ////////////////////////////////////////////////////////////
    // configured state of each switch from its 4-bit selector
    always @* begin
        for (i = 0; i < 3; i = i + 1) begin
            case (switch_config[i*4 +: 4])
                `SW_ON:        want_on[i] = 1'b1;
                `SW_TIMER_ONE: want_on[i] = pulse[0];
                `SW_TIMER_TWO: want_on[i] = pulse[1];
                default:       want_on[i] = 1'b0;
            endcase
            restart_clear[i] = (switch_config[i*4 +: 4] == `SW_TIMER_ONE) ||
                               (switch_config[i*4 +: 4] == `SW_TIMER_TWO);
            ov_hit[i] = overvolt && normal_mode && !ov_dis[i];
        end
    end

    // timer control next value: write, or clearing at restart entry
    always @* begin
        timer_next = timer_ctrl_reg;
        if (reg_write && reg_addr == `TIMER_CTRL_ADDR) begin
            timer_next = reg_wdata & `TIMER_CTRL_WMASK;
        end
        // only restart clears settings; other faults leave them alone
        if (restart_entry) begin
            if (restart_clear[0] || restart_clear[1] || restart_clear[2]) begin
                timer_next = `TIMER_CTRL_RESET;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // register file
    always @(posedge core_clk) begin
        if (rst) begin
            timer_ctrl_reg    <= `TIMER_CTRL_RESET;
            shutdown_ctrl_reg <= `SHUTDOWN_CTRL_RESET;
            reg_rdata         <= 16'h0000;
        end else begin
            timer_ctrl_reg <= timer_next;
            if (reg_write && reg_addr == `SHUTDOWN_CTRL_ADDR) begin
                shutdown_ctrl_reg <= reg_wdata & `SHUTDOWN_CTRL_WMASK;
            end
            // read data registered; unmapped addresses read zero
            if (reg_read) begin
                case (reg_addr)
                    `TIMER_CTRL_ADDR:    reg_rdata <= timer_ctrl_reg;
                    `SHUTDOWN_CTRL_ADDR: reg_rdata <= shutdown_ctrl_reg;
                    default:             reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // overvoltage shutdown and recovery per switch
    always @(posedge core_clk) begin
        if (rst) begin
            ov_off_reg     <= 3'h0;
            ov_latched_reg <= 3'h0;
            ov_prev_reg    <= 1'b0;
        end else begin
            ov_prev_reg <= overvolt;
            ov_off_reg  <= ov_hit;
            for (j = 0; j < 3; j = j + 1) begin
                // leaving overvoltage without recovery keeps the switch off
                if (ov_prev_reg && !overvolt && ov_off_reg[j] &&
                    !shutdown_ctrl_reg[`OV_REC_ONE_BIT + j]) begin
                    ov_latched_reg[j] <= 1'b1;
                end else if (reg_write && reg_addr == `SHUTDOWN_CTRL_ADDR) begin
                    ov_latched_reg[j] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // outputs: switches, wake and raw timer pulses
    always @(posedge core_clk) begin
        if (rst) begin
            switch_drive <= 3'h0;
            cyclic_wake  <= 1'b0;
            timer_pulse  <= 2'h0;
        end else begin
            for (k = 0; k < 3; k = k + 1) begin
                switch_drive[k] <= want_on[k] && !ov_off_reg[k] && !ov_latched_reg[k] &&
                                   !(shutdown_ctrl_reg[`OT_SCOPE_BIT] ? overtemp[k]
                                                                     : |overtemp);
            end
            // wake runs alongside sensing from the same pulse
            case (wake_sel)
                2'b01:   cyclic_wake <= pulse[0];
                2'b10:   cyclic_wake <= pulse[1];
                default: cyclic_wake <= 1'b0;
            endcase
            timer_pulse <= pulse;
        end
    end
endmodule // cyclic_timer_ctrl

/* include/cyclic_timer_defines.vh */
// constants for the cyclic timer and high-side shutdown block
// assumes a 250 MHz core clock standing in for the internal oscillator
`ifndef CYCLIC_TIMER_DEFINES_VH
`define CYCLIC_TIMER_DEFINES_VH
// register addresses on the serial register port
`define TIMER_CTRL_ADDR      7'h06
`define SHUTDOWN_CTRL_ADDR   7'h07
// reset values
`define TIMER_CTRL_RESET     16'h0000
`define SHUTDOWN_CTRL_RESET  16'h0000
// writable bit masks, reserved bits cleared
`define TIMER_CTRL_WMASK     16'heff7
`define SHUTDOWN_CTRL_WMASK  16'h7bff
// timer control field positions
`define T1_PER_LSB           0
`define T1_ON_LSB            4
`define WAKE_SEL_LSB         7
`define T2_PER_LSB           9
`define T2_ON_LSB            13
// shutdown control field positions
`define OV_DIS_ONE_BIT       7
`define OV_DIS_TWO_BIT       8
`define OV_DIS_THREE_BIT     9
`define OT_SCOPE_BIT         11
`define OV_REC_ONE_BIT       12
// switch configuration codes
`define SW_OFF               4'h0
`define SW_ON                4'h1
`define SW_TIMER_ONE         4'h2
`define SW_TIMER_TWO         4'h3
// time base: one tick per 100 us
`define TICK_TIME_NS         100000
`define CLK_PERIOD_NS        4
`define TICK_CYCLES          (`TICK_TIME_NS / `CLK_PERIOD_NS)
// last step count, TICK_CYCLES - 1; keep the two in step
`define TICK_LAST            15'h61a7
// restart value: the restart edge and the tick register already use two cycles
`define TICK_FIRST           15'h0002
`endif

/* hdl/cyclic_timer_unit.v */
// one cyclic timer: period and on-time decode and pulse generation
// assumes a one-cycle tick every 100 us from the parent, whose step restarts with the period
`include "cyclic_timer_defines.vh"
module cyclic_timer_unit (
    // clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // time base, one tick from this timer's own prescaler
    input  wire       tick,
    // configuration
    input  wire [2:0] period_code,
    input  wire [2:0] on_code,
    // output pulse
    output reg        pulse_reg
);
    reg  [15:0] count_reg;   // ticks into current period
    reg  [15:0] period_ticks; // period in 100 us ticks
    reg  [15:0] on_ticks;     // on-time in 100 us ticks
    reg  [2:0]  last_on_reg;  // detects a new on-time write
    wire        running = (on_code != 3'h0) && (on_code < 3'h6);

    ////////////////////////////////////////////////////////////
    // period decode
    always @* begin
        case (period_code)
            3'h0: period_ticks = 16'h0064; // 10 ms
            3'h1: period_ticks = 16'h00c8; // 20 ms
            3'h2: period_ticks = 16'h01f4; // 50 ms
            3'h3: period_ticks = 16'h03e8; // 100 ms
            3'h4: period_ticks = 16'h07d0; // 200 ms
            3'h5: period_ticks = 16'h1388; // 500 ms
            3'h6: period_ticks = 16'h2710; // 1 s
            default: period_ticks = 16'h4e20; // 2 s
        endcase
    end

    // on-time decode
    always @* begin
        case (on_code)
            3'h1: on_ticks = 16'h0001; // 0.1 ms
            3'h2: on_ticks = 16'h0003; // 0.3 ms
            3'h3: on_ticks = 16'h000a; // 1 ms
            3'h4: on_ticks = 16'h0064; // 10 ms
            3'h5: on_ticks = 16'h00c8; // 20 ms
            default: on_ticks = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////
    // counter restarts whenever on-time changes so a fresh code starts a period
    always @(posedge core_clk) begin
        if (rst) begin
            count_reg   <= 16'h0000;
            last_on_reg <= 3'h0;
            pulse_reg   <= 1'b0;
        end else begin
            last_on_reg <= on_code;
            if (!running || on_code != last_on_reg) begin
                count_reg <= 16'h0000;
            end else if (tick) begin
                if (count_reg + 16'h0001 >= period_ticks) begin
                    count_reg <= 16'h0000;
                end else begin
                    count_reg <= count_reg + 16'h0001;
                end
            end
            // stopped codes: 000 low, 110 and 111 high
            if (on_code == 3'h0) begin
                pulse_reg <= 1'b0;
            end else if (on_code[2:1] == 2'b11) begin
                pulse_reg <= 1'b1;
            end else begin
                pulse_reg <= (count_reg < on_ticks);
            end
        end
    end
endmodule // cyclic_timer_unit

/* verif/cyclic_timer_ctrl_sva.sv */
// port-level checker for the cyclic timer and shutdown block
// assumes it is bound onto cyclic_timer_ctrl by the testbench
`include "cyclic_timer_defines.vh"
module cyclic_timer_ctrl_sva (
    // clock and reset
    input logic        core_clk,
    input logic        rst,
    // register port
    input logic [6:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_write,
    input logic        reg_read,
    input logic [15:0] reg_rdata,
    // faults and outputs
    input logic        normal_mode,
    input logic        overvolt,
    input logic [2:0]  overtemp,
    input logic [2:0]  switch_drive,
    input logic        cyclic_wake,
    input logic [1:0]  timer_pulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [15:0] sd_reg; // shadow of the shutdown register from writes
    ////////////////////////////////////////
    // shadow update, reserved bits dropped as the design must
    always @(posedge core_clk) begin
        if (rst) sd_reg <= 16'h0000;
        else if (reg_write && reg_addr == `SHUTDOWN_CTRL_ADDR) sd_reg <= reg_wdata & `SHUTDOWN_CTRL_WMASK;
    end
    ////////////////////////////////////////
    rd_tmr_res_a: assert property (reg_read && reg_addr == `TIMER_CTRL_ADDR |=>
        reg_rdata[12] == 1'b0 && reg_rdata[3] == 1'b0) else $error("timer reserved bit read high");
    rd_sd_back_a: assert property (reg_read && !reg_write && reg_addr == `SHUTDOWN_CTRL_ADDR |=>
        reg_rdata == $past(sd_reg)) else $error("shutdown readback wrong");
    rd_unmap_a: assert property (reg_read && reg_addr > 7'h07 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    ov_one_a: assert property ((normal_mode && overvolt && !sd_reg[7]) [*3] |-> !switch_drive[0])
        else $error("switch one kept on in overvoltage");
    ov_two_a: assert property ((normal_mode && overvolt && !sd_reg[8]) [*3] |-> !switch_drive[1])
        else $error("switch two kept on in overvoltage");
    ov_three_a: assert property ((normal_mode && overvolt && !sd_reg[9]) [*3] |-> !switch_drive[2])
        else $error("switch three kept on in overvoltage");
    ot_all_a: assert property (((|overtemp) && !sd_reg[11]) [*3] |-> switch_drive == 3'b000)
        else $error("overtemp did not stop all switches");
    ot_one_a: assert property ((overtemp == 3'b010 && sd_reg[11]) [*3] |-> !switch_drive[1])
        else $error("overtemp switch left on");
    wake_src_a: assert property (cyclic_wake |-> (|timer_pulse) || (|$past(timer_pulse)))
        else $error("wake without timer pulse");
    cover property (timer_pulse[0] ##1 !timer_pulse[0]);
    cover property (cyclic_wake);
    cover property (normal_mode && overvolt && (|switch_drive));
endmodule // cyclic_timer_ctrl_sva

/* verif/switch_on_time_monitor.sv */
// load on a timer-driven switch: measures each on phase in cycles
// assumes a level input sampled on core_clk
module switch_on_time_monitor (
    input  logic        core_clk,
    input  logic        level,
    output logic [31:0] high_cycles, // length of last finished on phase
    output logic [31:0] run_cycles   // length of the current on phase
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        high_cycles = 32'h0000_0000;
        run_cycles = 32'h0000_0000;
    end
    // a falling level closes the phase, so a stuck-high output never reports
    always @(posedge core_clk) begin
        if (level) run_cycles <= run_cycles + 1;
        else if (run_cycles != 0) begin
            high_cycles <= run_cycles;
            run_cycles <= 32'h0000_0000;
        end
    end
endmodule // switch_on_time_monitor

/* verif/testbench.sv */
// self-checking bench for cyclic_timer_ctrl
// assumes the on-time monitor and the bound checker
`include "cyclic_timer_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [6:0]  reg_addr = 7'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic [11:0] switch_config = 12'h000;
    logic        normal_mode = 1'b1;
    logic        restart_entry = 1'b0;
    logic        overvolt = 1'b0;
    logic [2:0]  overtemp = 3'b000;
    logic [2:0]  switch_drive;
    logic        cyclic_wake;
    logic [1:0]  timer_pulse;
    logic [31:0] high_cycles;
    int          err_total = 0;
    int          checks_done = 0;
    // wake table: register word and expected wake level
    logic [15:0] wd [5] = '{16'h00e0, 16'h0160, 16'hc100, 16'hc1e0, 16'hc060};
    logic [4:0]  we = 5'b00101;
    always #2 core_clk = ~core_clk;
    cyclic_timer_ctrl cyclic_timer_ctrl_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .switch_config(switch_config), .normal_mode(normal_mode), .restart_entry(restart_entry),
        .overvolt(overvolt), .overtemp(overtemp), .switch_drive(switch_drive),
        .cyclic_wake(cyclic_wake), .timer_pulse(timer_pulse));
    switch_on_time_monitor switch_on_time_monitor_inst (.core_clk(core_clk), .level(timer_pulse[0]),
        .high_cycles(high_cycles), .run_cycles());
    ////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(posedge core_clk);
        #1 cmp(reg_rdata, exp);
    endtask
    // outputs lag the registers by about two cycles
    task automatic settle();
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic drive(input logic [11:0] cfg, input logic ov, input logic [2:0] ot);
        @(posedge core_clk);
        switch_config <= cfg;
        overvolt <= ov;
        overtemp <= ot;
    endtask
    // bounded wait for a level on the first timer output
    task automatic wait_pulse(input logic lvl, input int lim);
        int n;
        n = 0;
        while (timer_pulse[0] !== lvl && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= lim) begin
            err_total++;
            $display("CHECK FAILED at %0t: pulse wait ran out", $time);
            test_done();
        end
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        rd(`TIMER_CTRL_ADDR, 16'h0000);
        wr(`TIMER_CTRL_ADDR, 16'hffff);
        rd(`TIMER_CTRL_ADDR, 16'heff7);
        wr(`SHUTDOWN_CTRL_ADDR, 16'hffff);
        rd(`SHUTDOWN_CTRL_ADDR, 16'h7bff);
        rd(7'h09, 16'h0000);
        wr(`TIMER_CTRL_ADDR, 16'h0000);
        wr(`SHUTDOWN_CTRL_ADDR, 16'h0000);
        $display("registers done");
    endtask
    task automatic t_codes();
        logic [2:0] c;
        for (int i = 0; i < 3; i++) begin
            c = (i == 0) ? 3'h0 : 3'(i + 5);
            wr(`TIMER_CTRL_ADDR, {c, 1'b0, 3'h7, 2'h0, c, 1'b0, 3'h7});
            settle();
            cmp({14'h0000, timer_pulse}, (i == 0) ? 16'h0000 : 16'h0003);
        end
        $display("stopped codes done");
    endtask
    task automatic t_pulse();
        wr(`TIMER_CTRL_ADDR, 16'h0000);
        drive(12'h002, 1'b0, 3'b000);
        wr(`TIMER_CTRL_ADDR, 16'h0010);
        wait_pulse(1'b1, 10);
        repeat (100) @(posedge core_clk);
        #1 cmp({15'h0000, switch_drive[0]}, 16'h0001);
        wait_pulse(1'b0, 30000);
        settle();
        cmp(high_cycles[15:0], 16'(`TICK_CYCLES));
        cmp({15'h0000, switch_drive[0]}, 16'h0000);
        $display("pulse done");
    endtask
    task automatic t_wake();
        for (int i = 0; i < 5; i++) begin
            wr(`TIMER_CTRL_ADDR, wd[i]);
            settle();
            cmp({15'h0000, cyclic_wake}, {15'h0000, we[i]});
        end
        wr(`TIMER_CTRL_ADDR, 16'h00e0);
        settle();
        cmp({14'h0000, switch_drive[0], cyclic_wake}, 16'h0003);
        $display("wake done");
    endtask
    task automatic t_faults();
        drive(12'h111, 1'b0, 3'b000);
        wr(`SHUTDOWN_CTRL_ADDR, 16'h0280);
        drive(12'h111, 1'b1, 3'b000);
        settle();
        cmp({13'h0000, switch_drive}, 16'h0005);
        drive(12'h111, 1'b0, 3'b000);
        settle();
        cmp({13'h0000, switch_drive}, 16'h0005);
        wr(`SHUTDOWN_CTRL_ADDR, 16'h2000);
        drive(12'h111, 1'b1, 3'b000);
        settle();
        cmp({13'h0000, switch_drive}, 16'h0000);
        drive(12'h111, 1'b0, 3'b000);
        settle();
        cmp({13'h0000, switch_drive}, 16'h0002);
        wr(`SHUTDOWN_CTRL_ADDR, 16'h0800);
        drive(12'h111, 1'b0, 3'b010);
        settle();
        cmp({13'h0000, switch_drive}, 16'h0005);
        wr(`SHUTDOWN_CTRL_ADDR, 16'h0000);
        settle();
        cmp({13'h0000, switch_drive}, 16'h0000);
        drive(12'h111, 1'b1, 3'b000);
        normal_mode <= 1'b0;
        settle();
        cmp({13'h0000, switch_drive}, 16'h0007);
        drive(12'h000, 1'b0, 3'b000);
        normal_mode <= 1'b1;
        $display("faults done");
    endtask
    task automatic t_restart();
        wr(`TIMER_CTRL_ADDR, 16'h0012);
        for (int i = 0; i < 2; i++) begin
            drive((i == 0) ? 12'h000 : 12'h300, 1'b0, 3'b000);
            @(posedge core_clk);
            restart_entry <= 1'b1;
            @(posedge core_clk);
            restart_entry <= 1'b0;
            rd(`TIMER_CTRL_ADDR, (i == 0) ? 16'h0012 : 16'h0000);
        end
        $display("restart done");
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_codes();
        t_pulse();
        t_wake();
        t_faults();
        t_restart();
        test_done();
    end
endmodule // testbench
bind cyclic_timer_ctrl cyclic_timer_ctrl_sva cyclic_timer_ctrl_sva_inst (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .normal_mode(normal_mode), .overvolt(overvolt), .overtemp(overtemp),
    .switch_drive(switch_drive), .cyclic_wake(cyclic_wake), .timer_pulse(timer_pulse));
